// >>> wbc_defines.svh
// Offsets, field positions, reset values and timing counts of the watchdog boot configuration
// What this block does
// R1: Enable code 11 runs the watchdog always, sleep included, ignoring software enable.
// R2: Enable code 10 counts while the core runs and stops during sleep.
// R3: Enable code 01 follows the software enable bit; code 00 keeps the watchdog off.
// R4: Clock code 111 lets software pick the reference; codes 110 to 010 are reserved.
// R5: Clock code 001 selects the medium-frequency oscillator, 31.25 kHz, the default.
// R6: Clock code 000 selects the low-frequency oscillator output, 31.00 kHz.
// R7: Window code 111 or 110 loads window 111 with no closed delay, fully open.
// R8: Window codes 101 to 000 load themselves; closed delay 25 to 87.5 percent.
// R9: Open part is the remainder; only 111/110 allow unkeyed window writes, others need the key.
// R10: Unused bit 7 of the configuration word always reads back as one.
// R11: Configuration is latched at power-up and held until the next configuration load.
`ifndef WBC_DEFINES_SVH
`define WBC_DEFINES_SVH

// Register byte offsets
`define WBC_OFS_CONFIG     8'h00
`define WBC_OFS_CTRL       8'h04
`define WBC_OFS_KEY        8'h08
`define WBC_OFS_STATUS     8'h0C

// Control register fields
`define WBC_CTRL_SWON      0
`define WBC_CTRL_CS_LO     1
`define WBC_CTRL_WIN_LO    8

// Status register fields
`define WBC_STS_RUN        0
`define WBC_STS_CS_LO      1
`define WBC_STS_CLOSED_LO  4
`define WBC_STS_LOADED     7
`define WBC_STS_CLKRSVD    8
`define WBC_STS_LOCKED     9
`define WBC_STS_KEYARM     10

// Configuration word layout
`define WBC_CFG_BIT7       7

// Codes
`define WBC_EN_ALWAYS      2'h3
`define WBC_EN_RUNNING     2'h2
`define WBC_EN_SOFTWARE    2'h1
`define WBC_CLK_SOFT       3'h7
`define WBC_CLK_MF         3'h1
`define WBC_CLK_LF         3'h0
`define WBC_WIN_FREE_LO    3'h6
`define WBC_WIN_OPEN       3'h7
`define WBC_KEY_VALUE      8'hA5

// Reset values and timing
`define WBC_RST_CS         3'h0
`define WBC_SETTLE_CYC     2'h3

`endif

// >>> wbc_pkg.sv
// Types shared by the watchdog boot configuration block
package wbc_pkg;

	// Boot configuration word, bit 13 first
	typedef struct packed {
		logic [2:0] clk_cfg;
		logic [2:0] win_cfg;
		logic       unused7;
		logic [1:0] en_mode;
		logic [4:0] prescale;
	} wbc_cfg_t;

	// Decoded watchdog controls
	typedef struct packed {
		logic       run;
		logic [2:0] clk_sel;
		logic [2:0] closed;
		logic       locked;
		logic       clk_rsvd;
	} wbc_wd_t;

	// Load sequencer
	typedef enum logic [1:0] {
		WBC_ST_RESET  = 2'b00,
		WBC_ST_SETTLE = 2'b01,
		WBC_ST_RUN    = 2'b10
	} wbc_fsm_t;

	// Whole state of the top module
	typedef struct packed {
		wbc_fsm_t    fsm;
		logic [1:0]  settle;
		logic [13:0] sync1;
		logic [13:0] sync2;
		wbc_cfg_t    cfg;
		logic        loaded;
		logic        sw_on;
		logic [2:0]  sw_cs;
		logic [2:0]  window;
		logic        key_armed;
		logic        ack;
		logic [31:0] rdata;
		wbc_wd_t     wd;
	} wbc_state_t;

endpackage

// >>> wbc_decode.sv
// Combinational decode of the latched configuration into watchdog controls
`include "wbc_defines.svh"

module wbc_decode (
	// Latched configuration
	input  wire  wbc_pkg::wbc_cfg_t cfg,
	// Runtime controls
	input  wire  logic              sw_on,
	input  wire  logic [2:0]        sw_cs,
	input  wire  logic [2:0]        window,
	input  wire  logic              sleep,
	// Decoded result
	output       wbc_pkg::wbc_wd_t  wd
);

	// Closed delay in eighths of the period for a window value
	function automatic logic [2:0] closed_eighths(input logic [2:0] w);
		if (w >= `WBC_WIN_FREE_LO)
			closed_eighths = 3'h0; // [R7]
		else
			closed_eighths = 3'h7 - w; // [R8] [R9]
	endfunction

	// Enable, clock and window decode
	always_comb begin
		wd = '0;
		case (cfg.en_mode)
			`WBC_EN_ALWAYS:   wd.run = 1'b1; // [R1]
			`WBC_EN_RUNNING:  wd.run = ~sleep; // [R2]
			`WBC_EN_SOFTWARE: wd.run = sw_on; // [R3]
			default:          wd.run = 1'b0; // [R3]
		endcase
		case (cfg.clk_cfg)
			`WBC_CLK_SOFT: wd.clk_sel = sw_cs; // [R4]
			`WBC_CLK_MF:   wd.clk_sel = `WBC_CLK_MF; // [R5]
			`WBC_CLK_LF:   wd.clk_sel = `WBC_CLK_LF; // [R6]
			default: begin
				wd.clk_sel  = `WBC_CLK_MF; // Reserved codes fall back to default
				wd.clk_rsvd = 1'b1; // [R4]
			end
		endcase
		wd.closed = closed_eighths(window);
		wd.locked = (cfg.win_cfg < `WBC_WIN_FREE_LO); // [R9]
	end

endmodule

// >>> wbc_top.sv
// Watchdog boot configuration: word capture, decode and Wishbone register file
//
// Implementation choices: the Wishbone interface to the registers and the register offsets.
`include "wbc_defines.svh"

module wbc_top (
	// Clock and reset
	input  wire  logic        mclk,
	input  wire  logic        arst_n,
	// Wishbone classic slave
	input  wire  logic        wb_cyc_i,
	input  wire  logic        wb_stb_i,
	input  wire  logic        wb_we_i,
	input  wire  logic [7:0]  wb_adr_i,
	input  wire  logic [3:0]  wb_sel_i,
	input  wire  logic [31:0] wb_dat_i,
	output       logic [31:0] wb_dat_o,
	output       logic        wb_ack_o,
	// Non-volatile configuration word pins
	input  wire  logic [13:0] cfg_word_pin,
	// Core side
	input  wire  logic        core_sleep,
	input  wire  logic        cfg_reload,
	// Watchdog controls
	output       logic        wd_run,
	output       logic [2:0]  wd_clk_sel,
	output       logic [2:0]  wd_window,
	output       logic [2:0]  wd_closed_eighths,
	output       logic [4:0]  wd_prescale,
	output       logic        wd_window_locked,
	output       logic        cfg_loaded
);

	wbc_pkg::wbc_state_t st_r;
	wbc_pkg::wbc_state_t st_nxt;
	wbc_pkg::wbc_wd_t    wd_dec;
	wbc_pkg::wbc_cfg_t   cfg_in;

	// Power-on window value for a window code
	function automatic logic [2:0] por_window(input logic [2:0] code);
		if (code >= `WBC_WIN_FREE_LO)
			por_window = `WBC_WIN_OPEN; // [R7]
		else
			por_window = code; // [R8]
	endfunction

	// Read-back view of the configuration word
	function automatic logic [31:0] cfg_view(input wbc_pkg::wbc_cfg_t c);
		logic [13:0] w;
		w = c;
		w[`WBC_CFG_BIT7] = 1'b1; // [R10]
		cfg_view = {18'h0, w};
	endfunction

	// Decode of latched configuration and runtime settings
	wbc_decode u_decode (
		.cfg    (st_r.cfg),
		.sw_on  (st_r.sw_on),
		.sw_cs  (st_r.sw_cs),
		.window (st_r.window),
		.sleep  (core_sleep),
		.wd     (wd_dec)
	);

	assign cfg_in = st_r.sync2;

	// Next state: sync, load sequencer, bus slave, decoded outputs
	always_comb begin
		logic        req;
		logic        wr;
		logic        win_ok;
		logic [31:0] rd;
		req    = 1'b0;
		wr     = 1'b0;
		win_ok = 1'b0;
		rd     = 32'h0;
		st_nxt = st_r;

		// Two-stage pin synchroniser
		st_nxt.sync1 = cfg_word_pin;
		st_nxt.sync2 = st_r.sync1;

		// Capture the word once after reset or a reload request
		case (st_r.fsm)
			wbc_pkg::WBC_ST_RESET: begin
				st_nxt.settle = 2'h0;
				st_nxt.fsm    = wbc_pkg::WBC_ST_SETTLE;
			end
			wbc_pkg::WBC_ST_SETTLE: begin
				if (st_r.settle == `WBC_SETTLE_CYC) begin
					st_nxt.cfg    = cfg_in; // [R11]
					st_nxt.window = por_window(cfg_in.win_cfg); // [R7] [R8]
					st_nxt.loaded = 1'b1;
					st_nxt.fsm    = wbc_pkg::WBC_ST_RUN;
				end else begin
					st_nxt.settle = st_r.settle + 2'h1;
				end
			end
			wbc_pkg::WBC_ST_RUN: begin
				if (cfg_reload) begin
					st_nxt.settle = 2'h0;
					st_nxt.fsm    = wbc_pkg::WBC_ST_SETTLE; // [R11]
				end
			end
			default: begin
				st_nxt.fsm = wbc_pkg::WBC_ST_RESET;
			end
		endcase

		// Wishbone classic: one wait state, ack drops after one cycle
		req = wb_cyc_i & wb_stb_i & ~st_r.ack;
		wr  = req & wb_we_i;
		st_nxt.ack = req;

		// Window writes need a free window or an armed key
		win_ok = ~st_r.wd.locked | st_r.key_armed; // [R9]

		if (wr) begin
			case (wb_adr_i)
				`WBC_OFS_CTRL: begin
					if (wb_sel_i[0]) begin
						st_nxt.sw_on = wb_dat_i[`WBC_CTRL_SWON]; // [R3]
						st_nxt.sw_cs = wb_dat_i[`WBC_CTRL_CS_LO +: 3]; // [R4]
					end
					if (wb_sel_i[1]) begin
						if (win_ok)
							st_nxt.window = wb_dat_i[`WBC_CTRL_WIN_LO +: 3]; // [R9]
						st_nxt.key_armed = 1'b0; // Key is used up by any window-lane write
					end
				end
				`WBC_OFS_KEY: begin
					if (wb_sel_i[0])
						st_nxt.key_armed = (wb_dat_i[7:0] == `WBC_KEY_VALUE); // [R9]
				end
				default: begin
					st_nxt.key_armed = st_r.key_armed; // Read-only and unmapped ignore writes
				end
			endcase
		end

		// Read mux; unmapped offsets read zero
		case (wb_adr_i)
			`WBC_OFS_CONFIG: rd = cfg_view(st_r.cfg); // [R10]
			`WBC_OFS_CTRL: begin
				rd[`WBC_CTRL_SWON]        = st_r.sw_on;
				rd[`WBC_CTRL_CS_LO +: 3]  = st_r.sw_cs;
				rd[`WBC_CTRL_WIN_LO +: 3] = st_r.window;
			end
			`WBC_OFS_KEY: rd[0] = st_r.key_armed;
			`WBC_OFS_STATUS: begin
				rd[`WBC_STS_RUN]           = st_r.wd.run;
				rd[`WBC_STS_CS_LO +: 3]    = st_r.wd.clk_sel;
				rd[`WBC_STS_CLOSED_LO +: 3] = st_r.wd.closed;
				rd[`WBC_STS_LOADED]        = st_r.loaded;
				rd[`WBC_STS_CLKRSVD]       = st_r.wd.clk_rsvd;
				rd[`WBC_STS_LOCKED]        = st_r.wd.locked;
				rd[`WBC_STS_KEYARM]        = st_r.key_armed;
			end
			default: rd = 32'h0;
		endcase
		st_nxt.rdata = req ? rd : 32'h0;

		// Register the decoded controls
		st_nxt.wd = wd_dec; // [R1] [R2] [R5] [R6]
	end

	// Single state register
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Outputs straight from flip-flops
	assign wb_dat_o          = st_r.rdata;
	assign wb_ack_o          = st_r.ack;
	assign wd_run            = st_r.wd.run;
	assign wd_clk_sel        = st_r.wd.clk_sel;
	assign wd_window         = st_r.window;
	assign wd_closed_eighths = st_r.wd.closed;
	assign wd_prescale       = st_r.cfg.prescale;
	assign wd_window_locked  = st_r.wd.locked;
	assign cfg_loaded        = st_r.loaded;

endmodule

// >>> wbc_top_props.sv
// Concurrent checks on the ports of the watchdog boot configuration top
module wbc_top_props (
	// Clock, reset and bus
	input wire logic        mclk,
	input wire logic        arst_n,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_ack_o,
	input wire logic [31:0] wb_dat_o,
	// Word and watchdog controls
	input wire logic [13:0] cfg_word_pin,
	input wire logic        core_sleep,
	input wire logic        wd_run,
	input wire logic [2:0]  wd_clk_sel,
	input wire logic [2:0]  wd_window,
	input wire logic [2:0]  wd_closed_eighths,
	input wire logic [4:0]  wd_prescale,
	input wire logic        wd_window_locked,
	input wire logic        cfg_loaded
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0]  stab_r;
	logic [13:0] pin_q;
	logic        st;
	// Cycles since the word pins last moved, saturating
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n)
			stab_r <= 4'h0;
		else if ($changed(cfg_word_pin))
			stab_r <= 4'h0;
		else if (stab_r != 4'hF)
			stab_r <= stab_r + 4'h1;
	end
	// Word pins one edge back, so the edge of a fresh change is excluded
	always_ff @(posedge mclk) begin
		pin_q <= cfg_word_pin;
	end
	// Word long settled, not just changed, and captured
	assign st = (stab_r == 4'hF) && (pin_q == cfg_word_pin) && cfg_loaded;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!arst_n);
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
	ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("no ack");
	dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("stray data");
	closed_map_a: assert property ($past(cfg_loaded) |-> wd_closed_eighths ==
		(($past(wd_window) > 3'h5) ? 3'h0 : 3'h7 - $past(wd_window))) else $error("closed");
	run_always_a: assert property (st && cfg_word_pin[6:5] == 2'h3 |-> wd_run)
		else $error("run always");
	run_sleep_a: assert property (st && cfg_word_pin[6:5] == 2'h2 |->
		wd_run == !$past(core_sleep)) else $error("run sleep");
	run_off_a: assert property (st && cfg_word_pin[6:5] == 2'h0 |-> !wd_run)
		else $error("run off");
	clk_fixed_a: assert property (st && cfg_word_pin[13:12] == 2'h0 |->
		wd_clk_sel == {2'h0, cfg_word_pin[11]}) else $error("clock select");
	lock_map_a: assert property (st |-> wd_window_locked == (cfg_word_pin[10:9] != 2'h3))
		else $error("lock");
	hold_cfg_a: assert property ($changed(cfg_word_pin) && cfg_loaded |=>
		$stable(wd_prescale)[*3]) else $error("word not held");
endmodule

// >>> tb.sv
// Self-checking bench for the watchdog boot configuration block
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_total++; \
	$display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        mclk, arst_n, wb_cyc_i, wb_stb_i, wb_we_i, core_sleep, cfg_reload;
	logic        wb_ack_o, wd_run, wd_window_locked, cfg_loaded, m_on, m_slp, er, lk;
	logic [7:0]  wb_adr_i;
	logic [3:0]  wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, q, r;
	logic [13:0] cfg_word_pin;
	logic [2:0]  wd_clk_sel, wd_window, wd_closed_eighths, m_cs, m_win, w, c, ec, ecl;
	logic [4:0]  wd_prescale;
	int          err_total = 0, cmp_count = 0, cyc_n = 0, seed = 32'h0caf;
	wbc_top u_dut (.mclk, .arst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
		.wb_dat_i, .wb_dat_o, .wb_ack_o, .cfg_word_pin, .core_sleep, .cfg_reload, .wd_run,
		.wd_clk_sel, .wd_window, .wd_closed_eighths, .wd_prescale, .wd_window_locked,
		.cfg_loaded);
	// Verdict and end of run
	task close_out;
		if (err_total == 0 && cmp_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// One classic Wishbone cycle, read data left in q
	task wbx(input logic we, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, we, a, d};
		do @(posedge mclk); while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		{wb_cyc_i, wb_stb_i} <= 2'h0;
	endtask
	// Compare registers and ports with the model
	task chk;
		c = cfg_word_pin[13:11];
		ec = (c == 3'h7) ? m_cs : ((c == 3'h0) ? 3'h0 : 3'h1);
		lk = (cfg_word_pin[10:9] != 2'h3);
		ecl = (m_win > 3'h5) ? 3'h0 : 3'h7 - m_win;
		case (cfg_word_pin[6:5])
			2'h3: er = 1'b1;
			2'h2: er = !m_slp;
			2'h1: er = m_on;
			default: er = 1'b0;
		endcase
		wbx(0, 8'h00, 0);
		`CHK(q, {18'h0, cfg_word_pin | 14'h0080})
		wbx(0, 8'h04, 0);
		`CHK(q, {21'h0, m_win, 4'h0, m_cs, m_on})
		wbx(0, 8'h0C, 0);
		`CHK(q, {21'h0, 1'b0, lk, (c inside {[3'h2:3'h6]}), 1'b1, ecl, ec, er})
		`CHK(wd_window, m_win)
		`CHK({wd_run, wd_clk_sel}, {er, ec})
		`CHK({wd_closed_eighths, wd_window_locked, cfg_loaded}, {ecl, lk, 1'b1})
		`CHK(wd_prescale, cfg_word_pin[4:0])
	endtask
	initial begin
		mclk = 0;
		forever #5 mclk = ~mclk;
	end
	// Hang guard
	always @(posedge mclk) begin
		cyc_n <= cyc_n + 1;
		if (cyc_n == 6000) begin
			err_total++;
			close_out;
		end
	end
	initial begin
		{arst_n, wb_cyc_i, wb_stb_i, wb_we_i, core_sleep, cfg_reload} = 6'h0;
		{wb_adr_i, wb_sel_i, wb_dat_i, cfg_word_pin} = '0;
		{m_on, m_cs} = 4'h0;
		repeat (10) @(posedge mclk);
		arst_n <= 1'b1;
		wb_sel_i <= 4'hF;
		repeat (20) @(posedge mclk);
		for (int i = 0; i < 16; i++) begin
			r = $random(seed);
			w = 3'(i * 3 + 1);
			m_slp = r[9];
			cfg_word_pin <= {i[2:0], w, r[7], i[3:2], r[4:0]};
			core_sleep <= m_slp;
			@(posedge mclk) cfg_reload <= 1'b1;
			@(posedge mclk) cfg_reload <= 1'b0;
			repeat (14) @(posedge mclk);
			m_win = (w > 3'h5) ? 3'h7 : w;
			chk;
			// Unkeyed window write honoured only when free
			wbx(1, 8'h04, {21'h0, r[20:18], 4'h0, r[17:15], r[14]});
			{m_cs, m_on} = r[17:14];
			if (w > 3'h5) m_win = r[20:18];
			wbx(1, 8'h00, 32'hFFFFFFFF);
			wbx(1, 8'h10, 32'hFFFFFFFF);
			wbx(0, 8'h10, 0);
			`CHK(q, 32'h0)
			chk;
			// Keyed window write
			wbx(1, 8'h08, 32'hA5);
			wbx(0, 8'h08, 0);
			`CHK(q, 32'h1)
			wbx(1, 8'h04, {21'h0, r[23:21], 4'h0, m_cs, m_on});
			m_win = r[23:21];
			chk;
		end
		close_out;
	end
endmodule
bind wbc_top wbc_top_props u_props (.mclk, .arst_n, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
	.wb_dat_o, .cfg_word_pin, .core_sleep, .wd_run, .wd_clk_sel, .wd_window,
	.wd_closed_eighths, .wd_prescale, .wd_window_locked, .cfg_loaded);
